// file: rtl/ursf_top.sv
// Receive side of an asynchronous serial port with its status flags,
// APB register slave and a masked level interrupt.
// Assumes rx_pin is asynchronous to pclk; APB master follows AMBA APB3.
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ps
module ursf_top (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output      logic [31:0] prdata,
    output      logic        pready,
    output      logic        pslverr,
    // Serial line
    input  wire logic        rx_pin,
    // Interrupt
    output      logic        irq
);
    // Synchroniser, line idles high
    logic sync1_q, sync2_q;

    // Receiver state
    ursf_pkg::ursf_rx_state_t st_q, st_d;
    logic [9:0] tick_q, tick_d;
    logic [3:0] bit_q, bit_d;
    logic [8:0] shift_q, shift_d;
    logic       par_q, par_d;
    logic       push;
    ursf_pkg::ursf_entry_t wentry;

    // Registers
    logic                        address_detect_enable_q, address_detect_enable_d;
    logic                        ovr_q, ovr_d;
    logic [2:0]                  ctrl_q, ctrl_d;
    logic [ursf_pkg::IRQ_W-1:0]  ist_q, ist_d, imask_q, imask_d;
    logic [31:0]                 prdata_d;
    logic                        pslverr_d, irq_d;
    logic                        flush, pop;

    // FIFO
    ursf_pkg::ursf_entry_t head;
    logic empty, full;

    logic acc, wr, rd, nine, char_done, addr_char;
    logic [15:0] status;

    assign acc  = psel && penable;
    assign wr   = acc && pwrite;
    // Reads are answered from the setup cycle so data stands with pready
    assign rd   = psel && !penable && !pwrite;
    assign nine = ctrl_q[ursf_pkg::NINE_BIT_BIT];

    // Two-flop synchroniser on the line input
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
        end
        else
        begin
            sync1_q <= rx_pin;
            sync2_q <= sync1_q;
        end
    end

    // Receive state machine: sample mid-bit, LSB first
    always_comb
    begin
        st_d      = st_q;
        tick_d    = tick_q;
        bit_d     = bit_q;
        shift_d   = shift_q;
        par_d     = par_q;
        push      = 1'b0;
        char_done = 1'b0;
        wentry    = '0;
        unique case (st_q)
            ursf_pkg::RX_IDLE:
            begin
                tick_d = '0;
                if (!sync2_q)
                    st_d = ursf_pkg::RX_START;
            end
            ursf_pkg::RX_START:
            begin
                tick_d = tick_q + 1'b1;
                if (tick_q == ursf_pkg::HALF_CNT_MAX)
                begin
                    tick_d = '0;
                    bit_d  = '0;
                    // A glitch shorter than half a bit is not a start
                    st_d   = sync2_q ? ursf_pkg::RX_IDLE : ursf_pkg::RX_DATA;
                end
            end
            ursf_pkg::RX_DATA:
            begin
                tick_d = tick_q + 1'b1;
                if (tick_q == ursf_pkg::BIT_CNT_MAX)
                begin
                    tick_d  = '0;
                    shift_d = {sync2_q, shift_q[8:1]};
                    bit_d   = bit_q + 1'b1;
                    if (bit_q == (nine ? 4'h8 : 4'h7))
                    begin
                        if (!nine)
                            shift_d = {1'b0, sync2_q, shift_q[8:2]};
                        st_d = ctrl_q[ursf_pkg::PAR_EN_BIT] ? ursf_pkg::RX_PARITY
                                                             : ursf_pkg::RX_STOP;
                    end
                end
            end
            ursf_pkg::RX_PARITY:
            begin
                tick_d = tick_q + 1'b1;
                if (tick_q == ursf_pkg::BIT_CNT_MAX)
                begin
                    tick_d = '0;
                    par_d  = (^shift_q) ^ sync2_q ^ ctrl_q[ursf_pkg::PAR_ODD_BIT];
                    st_d   = ursf_pkg::RX_STOP;
                end
            end
            ursf_pkg::RX_STOP:
            begin
                tick_d = tick_q + 1'b1;
                if (tick_q == ursf_pkg::BIT_CNT_MAX)
                begin
                    tick_d         = '0;
                    char_done      = 1'b1;
                    // In nine-bit address mode only address characters are kept; in eight-bit mode all are kept
                    push           = !(address_detect_enable_q && nine) || shift_q[8];
                    wentry.data    = shift_q;
                    wentry.par_err = par_q && ctrl_q[ursf_pkg::PAR_EN_BIT];
                    wentry.frm_err = !sync2_q;
                    par_d          = 1'b0;
                    st_d           = ursf_pkg::RX_IDLE;
                end
            end
        endcase
        // Clearing overrun also drops a half-built character
        if (flush)
        begin
            st_d    = ursf_pkg::RX_IDLE;
            shift_d = '0;
            par_d   = 1'b0;
            push    = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q    <= ursf_pkg::RX_IDLE;
            tick_q  <= '0;
            bit_q   <= '0;
            shift_q <= '0;
            par_q   <= 1'b0;
        end
        else
        begin
            st_q    <= st_d;
            tick_q  <= tick_d;
            bit_q   <= bit_d;
            shift_q <= shift_d;
            par_q   <= par_d;
        end
    end

    assign addr_char = char_done && address_detect_enable_q && nine && shift_q[8];

    // Buffer of received characters with per-entry error flags
    ursf_fifo u_fifo (
        .pclk    (pclk),
        .presetn (presetn),
        .flush   (flush),
        .push    (push && !full),
        .wdata   (wentry),
        .pop     (pop),
        .head_q  (head),
        .empty   (empty),
        .full    (full)
    );

    // Status word as software sees it
    always_comb
    begin
        status                         = ursf_pkg::STATUS_RST;
        status[ursf_pkg::ADDR_DET_BIT] = address_detect_enable_q;
        status[ursf_pkg::RX_IDLE_BIT]  = (st_q == ursf_pkg::RX_IDLE);
        status[ursf_pkg::PAR_ERR_BIT]  = head.par_err;
        status[ursf_pkg::FRM_ERR_BIT]  = head.frm_err;
        status[ursf_pkg::OVERRUN_BIT]  = ovr_q;
        status[ursf_pkg::DATA_AV_BIT]  = !empty;
    end

    // Register writes, flag updates, read mux and interrupt
    always_comb
    begin
        address_detect_enable_d   = address_detect_enable_q;
        ctrl_d    = ctrl_q;
        imask_d   = imask_q;
        ist_d     = ist_q;
        ovr_d     = ovr_q;
        flush     = 1'b0;
        pop       = 1'b0;
        prdata_d  = '0;
        pslverr_d = 1'b0;
        if (wr)
        begin
            unique case (paddr)
                ursf_pkg::STATUS_OFF:
                begin
                    address_detect_enable_d = pwdata[ursf_pkg::ADDR_DET_BIT];
                    // Only a one-to-zero transition counts; writing one does nothing
                    if (ovr_q && !pwdata[ursf_pkg::OVERRUN_BIT])
                    begin
                        ovr_d = 1'b0;
                        flush = 1'b1;
                    end
                end
                ursf_pkg::CTRL_OFF:     ctrl_d  = pwdata[2:0];
                ursf_pkg::IRQ_STAT_OFF: ist_d   = ist_q & ~pwdata[ursf_pkg::IRQ_W-1:0];
                ursf_pkg::IRQ_MASK_OFF: imask_d = pwdata[ursf_pkg::IRQ_W-1:0];
                default:                ;
            endcase
        end
        else if (rd)
        begin
            unique case (paddr)
                ursf_pkg::STATUS_OFF:   prdata_d = {16'h0000, status};
                ursf_pkg::RXDATA_OFF:
                begin
                    prdata_d = {23'h000000, head.data};
                    pop      = 1'b1;
                end
                ursf_pkg::CTRL_OFF:     prdata_d = {29'h00000000, ctrl_q};
                ursf_pkg::IRQ_STAT_OFF: prdata_d = {28'h0000000, ist_q};
                ursf_pkg::IRQ_MASK_OFF: prdata_d = {28'h0000000, imask_q};
                default:                pslverr_d = 1'b1;
            endcase
        end
        // Write refusal decided in setup so pslverr rises together with pready
        if (psel && !penable && pwrite)
            pslverr_d = !(paddr inside {ursf_pkg::STATUS_OFF, ursf_pkg::CTRL_OFF,
                          ursf_pkg::IRQ_STAT_OFF, ursf_pkg::IRQ_MASK_OFF});
        // Overrun: character completes while buffer full; clear beats set
        if (push && full && !flush)
            ovr_d = 1'b1;
        // Events set sticky bits after the write-one-to-clear so sets win
        if (push && !full && !flush)
            ist_d[ursf_pkg::IRQ_RXDATA_BIT] = 1'b1;
        if (push && full && !flush)
            ist_d[ursf_pkg::IRQ_OVR_BIT] = 1'b1;
        if (push && (wentry.par_err || wentry.frm_err))
            ist_d[ursf_pkg::IRQ_ERR_BIT] = 1'b1;
        if (addr_char)
            ist_d[ursf_pkg::IRQ_ADDR_BIT] = 1'b1;
        irq_d = |(ist_d & imask_d);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            address_detect_enable_q <= 1'b0;
            ovr_q   <= 1'b0;
            ctrl_q  <= ursf_pkg::CTRL_RST;
            ist_q   <= ursf_pkg::IRQ_RST;
            imask_q <= ursf_pkg::IRQ_RST;
            prdata  <= '0;
            pslverr <= 1'b0;
            pready  <= 1'b0;
            irq     <= 1'b0;
        end
        else
        begin
            address_detect_enable_q <= address_detect_enable_d;
            ovr_q   <= ovr_d;
            ctrl_q  <= ctrl_d;
            ist_q   <= ist_d;
            imask_q <= imask_d;
            prdata  <= prdata_d;
            pslverr <= pslverr_d;
            pready  <= psel && !penable; // Zero-wait answer in access phase
            irq     <= irq_d;
        end
    end
endmodule

// file: rtl/ursf_pkg.sv
// Package for the receive status flag block: register map, field positions,
// reset values and timing counts.
// Assumes a 32-bit APB bus, byte addresses, one aligned word per register.
package ursf_pkg;

    // Register byte offsets
    localparam logic [7:0] STATUS_OFF   = 8'h00;
    localparam logic [7:0] RXDATA_OFF   = 8'h04;
    localparam logic [7:0] CTRL_OFF     = 8'h08;
    localparam logic [7:0] IRQ_STAT_OFF = 8'h0C;
    localparam logic [7:0] IRQ_MASK_OFF = 8'h10;

    // Status/control field positions
    localparam int ADDR_DET_BIT = 5;
    localparam int RX_IDLE_BIT  = 4;
    localparam int PAR_ERR_BIT  = 3;
    localparam int FRM_ERR_BIT  = 2;
    localparam int OVERRUN_BIT  = 1;
    localparam int DATA_AV_BIT  = 0;

    // Control register fields
    localparam int NINE_BIT_BIT = 0;
    localparam int PAR_EN_BIT   = 1;
    localparam int PAR_ODD_BIT  = 2;

    // Interrupt status fields
    localparam int IRQ_RXDATA_BIT = 0;
    localparam int IRQ_OVR_BIT    = 1;
    localparam int IRQ_ERR_BIT    = 2;
    localparam int IRQ_ADDR_BIT   = 3;
    localparam int IRQ_W          = 4;

    // Reset values
    localparam logic [15:0]      STATUS_RST = 16'h0000;
    localparam logic [2:0]       CTRL_RST   = 3'h0;
    localparam logic [IRQ_W-1:0] IRQ_RST    = 4'h0;

    // Receive buffer geometry
    localparam int FIFO_DEPTH = 4;
    localparam int FIFO_AW    = 2;
    localparam int ENTRY_W    = 11;

    // Bit timing: baud rate and clock
    localparam int CLK_HZ       = 100_000_000;
    localparam int BAUD_HZ      = 115_200;
    localparam int BIT_CYCLES   = CLK_HZ / BAUD_HZ;
    localparam int HALF_CYCLES  = BIT_CYCLES / 2;
    localparam logic [9:0] BIT_CNT_MAX  = 10'(BIT_CYCLES - 1);
    localparam logic [9:0] HALF_CNT_MAX = 10'(HALF_CYCLES - 1);

    // One stored character: data bits, parity and framing error
    typedef struct packed {
        logic       frm_err;
        logic       par_err;
        logic [8:0] data;
    } ursf_entry_t;

    typedef enum logic [2:0] {
        RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP
    } ursf_rx_state_t;

endpackage

// file: rtl/ursf_fifo.sv
// Small receive FIFO storing characters with their error flags.
// Assumes one clock; pop and flush come from the owner's register logic.
`timescale 1ns/1ps
module ursf_fifo (
    // Clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // Control
    input  wire logic                 flush,
    input  wire logic                 push,
    input  wire ursf_pkg::ursf_entry_t wdata,
    input  wire logic                 pop,
    // Status
    output      ursf_pkg::ursf_entry_t head_q,
    output      logic                 empty,
    output      logic                 full
);
    ursf_pkg::ursf_entry_t mem_q [ursf_pkg::FIFO_DEPTH];
    ursf_pkg::ursf_entry_t mem_d [ursf_pkg::FIFO_DEPTH];
    logic [ursf_pkg::FIFO_AW-1:0] rd_q, rd_d, wr_q, wr_d;
    logic [ursf_pkg::FIFO_AW:0]   cnt_q, cnt_d;
    ursf_pkg::ursf_entry_t        head_d;
    logic                         do_push, do_pop;

    assign empty = (cnt_q == '0);
    assign full  = (cnt_q == (ursf_pkg::FIFO_AW+1)'(ursf_pkg::FIFO_DEPTH));

    // Pointer and storage update; flush drops everything held
    always_comb
    begin
        do_push = push && !full;
        do_pop  = pop && !empty;
        mem_d   = mem_q;
        rd_d    = rd_q;
        wr_d    = wr_q;
        cnt_d   = cnt_q;
        if (flush)
        begin
            rd_d  = '0;
            wr_d  = '0;
            cnt_d = '0;
        end
        else
        begin
            if (do_push)
            begin
                mem_d[wr_q] = wdata;
                wr_d        = wr_q + 1'b1;
            end
            if (do_pop)
                rd_d = rd_q + 1'b1;
            if (do_push && !do_pop)
                cnt_d = cnt_q + 1'b1;
            else if (do_pop && !do_push)
                cnt_d = cnt_q - 1'b1;
        end
        // Head shows the oldest character, registered for clean reads
        head_d = mem_d[rd_d];
        if (cnt_d == '0)
            head_d = '0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rd_q   <= '0;
            wr_q   <= '0;
            cnt_q  <= '0;
            head_q <= '0;
            for (int i = 0; i < ursf_pkg::FIFO_DEPTH; i++)
                mem_q[i] <= '0;
        end
        else
        begin
            rd_q   <= rd_d;
            wr_q   <= wr_d;
            cnt_q  <= cnt_d;
            head_q <= head_d;
            mem_q  <= mem_d;
        end
    end
endmodule

// file: testbench/ursf_asserts.sv
// Checker for the receive status block: APB timing and status word shape.
// Assumes it is bound to ursf_top and sees only that module's ports.
`timescale 1ns/1ps
module ursf_checker (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Serial line and interrupt
    input wire logic        rx_pin,
    input wire logic        irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Decoded views of the transfer in flight
    logic setup;
    logic mapped;
    logic st_rd;
    assign setup  = psel && !penable;
    assign mapped = paddr inside {ursf_pkg::STATUS_OFF, ursf_pkg::RXDATA_OFF,
        ursf_pkg::CTRL_OFF, ursf_pkg::IRQ_STAT_OFF, ursf_pkg::IRQ_MASK_OFF};
    assign st_rd  = pready && !pwrite && paddr == ursf_pkg::STATUS_OFF;

    a_ready_after_setup: assert property (setup |=> pready)
        else $error("pready missing after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    a_unmapped_refused: assert property (setup && !mapped |=> pready && pslverr)
        else $error("unmapped access not refused");
    a_rxdata_write_refused: assert property (setup && pwrite
        && paddr == ursf_pkg::RXDATA_OFF |=> pslverr)
        else $error("write to receive data not refused");
    a_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    a_status_upper_zero: assert property (st_rd |-> prdata[31:6] == 26'h0)
        else $error("status upper bits set");
    a_error_needs_head: assert property (st_rd && (prdata[3] || prdata[2]) |-> prdata[0])
        else $error("error flag without head character");

    // Main scenarios seen at the ports
    c_overrun_read: cover property (st_rd && prdata[1]);
    c_refused: cover property (pready && pslverr);
    c_irq_rise: cover property ($rose(irq));
endmodule

bind ursf_top ursf_checker i_ursf_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin), .irq(irq));

// file: testbench/ursf_line_model.sv
// Far transmitter driving the serial line into the receiver.
// Assumes the line idles high and both ends use the package bit time.
`timescale 1ns/1ps
module ursf_line_model (
    // Clock
    input  wire logic pclk,
    // Serial line
    output      logic rx_pin
);
    initial rx_pin = 1'b1;

    // One bit time; changes only just after a clock edge
    task automatic put(input logic b);
        rx_pin <= b;
        repeat (ursf_pkg::BIT_CYCLES) @(posedge pclk);
    endtask

    // Start, data LSB first, optional even parity, stop, then one idle bit
    task automatic send(input logic [8:0] d, input logic nine, input logic par,
                        input logic bad_par, input logic stop);
        int n;
        n = nine ? 9 : 8;
        put(1'b0);
        for (int i = 0; i < n; i++)
            put(d[i]);
        if (par)
            put(^(d & (nine ? 9'h1FF : 9'h0FF)) ^ bad_par);
        put(stop);
        put(1'b1);
    endtask
endmodule

// file: testbench/ursf_tb_top.sv
// Bench for the receive status block: APB master tasks, serial line model,
// checker attached by bind. Assumes a 100 MHz pclk and the package map.
`timescale 1ns/1ps
module ursf_tb_top;
    // Design connections
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rx_pin;
    logic        irq;
    int          n_mismatch;
    int          compares;

    ursf_top i_ursf_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin), .irq(irq));
    ursf_line_model i_ursf_line_model (.pclk(pclk), .rx_pin(rx_pin));

    // Free-running 100 MHz clock
    always #5 pclk = ~pclk;

    task automatic final_report();
        if (n_mismatch == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; pready is sampled at the edge, so values are pre-update
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // No wait count is assumed; only the watchdog ends a hung wait
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp);
    endtask

    // Reset values, refused access, software cannot set read-only flags
    task automatic t_reset();
        logic [31:0] r;
        logic        e;
        rdchk(ursf_pkg::STATUS_OFF, 32'h10);
        rdchk(ursf_pkg::IRQ_MASK_OFF, 32'h0);
        apb(1'b0, 8'h40, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
        apb(1'b1, ursf_pkg::RXDATA_OFF, 32'h1FF, r, e);
        chk({31'h0, e}, 32'h1);
        wr(ursf_pkg::IRQ_MASK_OFF, 32'h2);
        rdchk(ursf_pkg::IRQ_MASK_OFF, 32'h2);
        wr(ursf_pkg::STATUS_OFF, 32'h1F);
        rdchk(ursf_pkg::STATUS_OFF, 32'h10);
    endtask

    // Parity then framing error; flags follow the head across reads
    task automatic t_errors();
        wr(ursf_pkg::CTRL_OFF, 32'h2);
        fork
            i_ursf_line_model.send(9'h055, 1'b0, 1'b1, 1'b1, 1'b1);
            begin
                repeat (3000) @(posedge pclk);
                rdchk(ursf_pkg::STATUS_OFF, 32'h0);
            end
        join
        i_ursf_line_model.send(9'h0A3, 1'b0, 1'b1, 1'b0, 1'b0);
        rdchk(ursf_pkg::STATUS_OFF, 32'h19);
        rdchk(ursf_pkg::RXDATA_OFF, 32'h55);
        rdchk(ursf_pkg::STATUS_OFF, 32'h15);
        rdchk(ursf_pkg::RXDATA_OFF, 32'hA3);
        rdchk(ursf_pkg::STATUS_OFF, 32'h10);
        // Odd parity: the flipped even bit is the correct odd bit
        wr(ursf_pkg::CTRL_OFF, 32'h6);
        i_ursf_line_model.send(9'h05A, 1'b0, 1'b1, 1'b1, 1'b1);
        rdchk(ursf_pkg::STATUS_OFF, 32'h11);
        rdchk(ursf_pkg::RXDATA_OFF, 32'h5A);
    endtask

    // Nine-bit mode with address detect: data characters are skipped
    task automatic t_address();
        wr(ursf_pkg::CTRL_OFF, 32'h1);
        wr(ursf_pkg::STATUS_OFF, 32'h20);
        i_ursf_line_model.send(9'h0AA, 1'b1, 1'b0, 1'b0, 1'b1);
        rdchk(ursf_pkg::STATUS_OFF, 32'h30);
        i_ursf_line_model.send(9'h1C3, 1'b1, 1'b0, 1'b0, 1'b1);
        rdchk(ursf_pkg::STATUS_OFF, 32'h31);
        rdchk(ursf_pkg::RXDATA_OFF, 32'h1C3);
    endtask

    // Fill past depth, check sticky overrun, interrupt, clear and flush
    task automatic t_overrun();
        wr(ursf_pkg::CTRL_OFF, 32'h0);
        for (int i = 0; i < 4; i++)
            i_ursf_line_model.send(9'h030 + 9'(i), 1'b0, 1'b0, 1'b0, 1'b1);
        rdchk(ursf_pkg::STATUS_OFF, 32'h31);
        chk({31'h0, irq}, 32'h0);
        i_ursf_line_model.send(9'h0FF, 1'b0, 1'b0, 1'b0, 1'b1);
        rdchk(ursf_pkg::STATUS_OFF, 32'h33);
        chk({31'h0, irq}, 32'h1);
        wr(ursf_pkg::STATUS_OFF, 32'h22);
        rdchk(ursf_pkg::STATUS_OFF, 32'h33);
        rdchk(ursf_pkg::RXDATA_OFF, 32'h30);
        wr(ursf_pkg::STATUS_OFF, 32'h20);
        rdchk(ursf_pkg::STATUS_OFF, 32'h30);
        rdchk(ursf_pkg::RXDATA_OFF, 32'h0);
        wr(ursf_pkg::IRQ_STAT_OFF, 32'hF);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
    endtask

    // Main sequence
    initial
    begin
        pclk       = 1'b0;
        presetn    = 1'b0;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = 8'h00;
        pwdata     = 32'h0;
        n_mismatch = 0;
        compares   = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_errors();
        t_address();
        t_overrun();
        final_report();
    end

    // Watchdog sized above the ten frames the run sends
    initial
    begin
        repeat (100000) @(posedge pclk);
        n_mismatch++;
        final_report();
    end
endmodule
